//--- src/rfs_top.sv
// rail fault supervisor: limits, turn-on timing, alert and apb registers
//
// How it works
// - timeout fault if rise misses budget
// - cold fault when temperature below limit
// - temperature source: die or external input
// - over-voltage fault above high limit
// - under-voltage fault below low limit
// - under-voltage armed only after timely rise
// - alert pulled low when fault detected
// - per-fault action: ignore, deglitch, off
// - clear command clears latched faults whose condition has gone
// - servo connects after ramp time
// - servo drives output toward target
// - fault with deglitch-off or off action can turn channel off
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module rfs_top
  import rfs_pkg::*;
(
  // clock and reset
  input  wire logic          i_sys_clk,
  input  wire logic          i_srst,
  // apb slave
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [7:0]    i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic [31:0]        o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  // sensed samples, same clock
  input  wire logic [DW-1:0] i_output_sense_input,
  input  wire logic [DW-1:0] i_die_temp,
  input  wire logic [DW-1:0] i_external_temp_sense,
  // managed supply
  output logic               o_supply_enable_out,
  output logic               o_servo_connected,
  output logic [GW-1:0]      o_servo_trim,
  // open-drain alert and interrupt
  output logic               o_alert_out_n_o,
  output logic               o_alert_out_n_oe,
  output logic               o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register address match, used by read and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [2:0]      ctrl_r;                      // on, ext temp, clear
  logic [DW-1:0]   target_r;                    // servo target
  logic [DW-1:0]   high_r;                      // output high limit
  logic [DW-1:0]   low_r;                       // output low limit
  logic [DW-1:0]   cold_r;                      // cold limit
  logic [TW-1:0]   budget_r;                    // turn-on budget, ticks
  logic [TW-1:0]   ramp_r;                      // ramp time, ticks
  logic [7:0]      action_r;                    // 2 bits per fault
  logic [GW-1:0]   dglt_r;                      // deglitch interval, ticks
  logic [NF-1:0]   fault_r;                     // latched faults
  logic [NF-1:0]   irq_r;                       // sticky irq status
  logic [NF-1:0]   mask_r;                      // irq enable
  rfs_state_type   state_r;                     // channel state
  logic [TW-1:0]   budget_cnt_r;                // ticks since enable
  logic [TW-1:0]   ramp_cnt_r;                  // ticks since enable
  logic            risen_r;                     // rose above low in budget
  logic            expired_r;                   // budget ran out unrisen
  logic [7:0]      tick_cnt_r;                  // prescaler
  logic            tick_r;                      // one-cycle microsecond tick
  logic [31:0]     rdata_r;                     // read data, held

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup    = i_psel && !i_penable;
  wire access   = i_psel && i_penable;
  wire wr_en    = access && i_pwrite;
  wire rd_en    = access && !i_pwrite;
  wire mapped   = hit(i_paddr, OFF_CTRL) || hit(i_paddr, OFF_TARGET) ||
                  hit(i_paddr, OFF_HIGH) || hit(i_paddr, OFF_LOW) ||
                  hit(i_paddr, OFF_COLD) || hit(i_paddr, OFF_BUDGET) ||
                  hit(i_paddr, OFF_RAMP) || hit(i_paddr, OFF_ACTION) ||
                  hit(i_paddr, OFF_DGLT) || hit(i_paddr, OFF_FAULT) ||
                  hit(i_paddr, OFF_IRQ) || hit(i_paddr, OFF_MASK) ||
                  hit(i_paddr, OFF_STATE);
  wire wr_ctrl  = wr_en && hit(i_paddr, OFF_CTRL);
  wire rd_irq   = rd_en && hit(i_paddr, OFF_IRQ);

  // zero wait states; unmapped addresses answer with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = access && !mapped;
  assign o_prdata  = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // read mux, captured in the setup cycle so prdata is a flop
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit(i_paddr, OFF_CTRL)) begin
      rd_mux[2:0] = {1'b0, ctrl_r[1:0]};
    end else if (hit(i_paddr, OFF_TARGET)) begin
      rd_mux[DW-1:0] = target_r;
    end else if (hit(i_paddr, OFF_HIGH)) begin
      rd_mux[DW-1:0] = high_r;
    end else if (hit(i_paddr, OFF_LOW)) begin
      rd_mux[DW-1:0] = low_r;
    end else if (hit(i_paddr, OFF_COLD)) begin
      rd_mux[DW-1:0] = cold_r;
    end else if (hit(i_paddr, OFF_BUDGET)) begin
      rd_mux[TW-1:0] = budget_r;
    end else if (hit(i_paddr, OFF_RAMP)) begin
      rd_mux[TW-1:0] = ramp_r;
    end else if (hit(i_paddr, OFF_ACTION)) begin
      rd_mux[7:0] = action_r;
    end else if (hit(i_paddr, OFF_DGLT)) begin
      rd_mux[GW-1:0] = dglt_r;
    end else if (hit(i_paddr, OFF_FAULT)) begin
      rd_mux[NF-1:0] = fault_r;
    end else if (hit(i_paddr, OFF_IRQ)) begin
      rd_mux[NF-1:0] = irq_r;
    end else if (hit(i_paddr, OFF_MASK)) begin
      rd_mux[NF-1:0] = mask_r;
    end else if (hit(i_paddr, OFF_STATE)) begin
      rd_mux[15:0] = {o_servo_trim, 3'b000, risen_r, expired_r,
                      o_supply_enable_out, state_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // microsecond tick
  wire tick_wrap = (tick_cnt_r == 8'(TICK_CYC - 1));
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + 1'b1;
      tick_r     <= tick_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault conditions
  logic [NF-1:0] cond;                          // raw conditions
  logic [NF-1:0] det;                           // filtered detections
  logic [NF-1:0] bypass;                        // no persistence needed
  logic [NF-1:0] off_act;                       // action turns channel off
  wire  [DW-1:0] temp = ctrl_r[CTRL_EXT_T] ? i_external_temp_sense
                                           : i_die_temp;
  wire           chan_on = (state_r != ST_OFF);

  assign cond[F_HIGH] = i_output_sense_input > high_r;
  assign cond[F_LOW]  = risen_r && chan_on &&
                        i_output_sense_input < low_r;
  assign cond[F_TMO]  = expired_r;
  assign cond[F_COLD] = temp < cold_r;

  // per-fault action fields and filters
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_flt
      wire rfs_act_type act = rfs_act_type'(action_r[2*g +: 2]);
      assign bypass[g]  = (act == ACT_IGNORE) || (act == ACT_OFF);
      assign off_act[g] = (act == ACT_DG_OFF) || (act == ACT_OFF);
      rfs_deglitch u_dglt (
        .i_sys_clk  (i_sys_clk),
        .i_srst     (i_srst),
        .i_cond     (cond[g]),
        .i_bypass   (bypass[g]),
        .i_tick     (tick_r),
        .i_interval (dglt_r),
        .o_hit      (det[g])
      );
    end
  endgenerate

  wire clr_cmd = wr_ctrl && i_pwdata[CTRL_CLR];
  wire off_req = |(fault_r & off_act);

  ////////////////////////////////////////////////////////////////////////////
  // fault latch and irq; a new detection wins over a clear
  wire [NF-1:0] fault_nxt = (clr_cmd ? '0 : fault_r) | det;
  wire [NF-1:0] new_flt   = det & ~fault_r;
  wire [NF-1:0] irq_nxt   = (rd_irq ? '0 : irq_r) | new_flt;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      fault_r <= '0;
      irq_r   <= '0;
    end else begin
      fault_r <= fault_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // open-drain alert: drive low while any fault is latched
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_alert_out_n_oe <= 1'b0;
      o_irq            <= 1'b0;
    end else begin
      o_alert_out_n_oe <= |fault_nxt;
      o_irq            <= |(irq_nxt & mask_r);
    end
  end
  assign o_alert_out_n_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // configuration writes
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl_r   <= '0;
      target_r <= RST_TARGET;
      high_r   <= RST_HIGH;
      low_r    <= RST_LOW;
      cold_r   <= RST_COLD;
      budget_r <= RST_BUDGET;
      ramp_r   <= RST_RAMP;
      action_r <= RST_ACTION;
      dglt_r   <= RST_DGLT;
      mask_r   <= '0;
      rdata_r  <= '0;
    end else begin
      if (setup) begin
        rdata_r <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_r <= i_pwdata[2:0];
      end else begin
        ctrl_r[CTRL_CLR] <= 1'b0;               // clear is a one-shot
      end
      if (wr_en && hit(i_paddr, OFF_TARGET)) target_r <= i_pwdata[DW-1:0];
      if (wr_en && hit(i_paddr, OFF_HIGH))   high_r   <= i_pwdata[DW-1:0];
      if (wr_en && hit(i_paddr, OFF_LOW))    low_r    <= i_pwdata[DW-1:0];
      if (wr_en && hit(i_paddr, OFF_COLD))   cold_r   <= i_pwdata[DW-1:0];
      if (wr_en && hit(i_paddr, OFF_BUDGET)) budget_r <= i_pwdata[TW-1:0];
      if (wr_en && hit(i_paddr, OFF_RAMP))   ramp_r   <= i_pwdata[TW-1:0];
      if (wr_en && hit(i_paddr, OFF_ACTION)) action_r <= i_pwdata[7:0];
      if (wr_en && hit(i_paddr, OFF_DGLT))   dglt_r   <= i_pwdata[GW-1:0];
      if (wr_en && hit(i_paddr, OFF_MASK))   mask_r   <= i_pwdata[NF-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel state machine
  rfs_state_type state_nxt;
  wire go_off   = !ctrl_r[CTRL_ON] || off_req;
  wire ramp_done = ramp_cnt_r >= ramp_r;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (!go_off) state_nxt = ST_RAMP;
      end
      ST_RAMP: begin
        if (go_off) state_nxt = ST_OFF;
        else if (ramp_done) state_nxt = ST_ON;
      end
      ST_ON: begin
        if (go_off) state_nxt = ST_OFF;
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  // budget and ramp timers, both measured from supply enable
  wire above_low = i_output_sense_input > low_r;
  wire budget_up = budget_cnt_r >= budget_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || state_r == ST_OFF) begin
      budget_cnt_r <= '0;
      ramp_cnt_r   <= '0;
      risen_r      <= 1'b0;
      expired_r    <= 1'b0;
    end else begin
      if (tick_r && !risen_r && !budget_up) begin
        budget_cnt_r <= budget_cnt_r + 1'b1;
      end
      if (tick_r && state_r == ST_RAMP && !ramp_done) begin
        ramp_cnt_r <= ramp_cnt_r + 1'b1;
      end
      // late rise never arms under-voltage
      if (above_low && !expired_r) begin
        risen_r <= 1'b1;
      end
      if (budget_up && !risen_r && !above_low) begin
        expired_r <= 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_supply_enable_out = (state_r != ST_OFF);
  assign o_servo_connected   = (state_r == ST_ON);

  ////////////////////////////////////////////////////////////////////////////
  // servo, held open until ramp time has passed
  rfs_servo u_servo (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_connect (o_servo_connected),
    .i_tick    (tick_r),
    .i_target  (target_r),
    .i_sense   (i_output_sense_input),
    .o_trim    (o_servo_trim)
  );

endmodule

//--- src/rfs_pkg.sv
// rail fault supervisor: shared constants, register map and types
package rfs_pkg;

  //////////////////////////////////////////////////////////////////////////
  // widths
  localparam int DW = 12;                       // sense sample width
  localparam int TW = 16;                       // tick count width
  localparam int GW = 8;                        // deglitch / trim width
  localparam int NF = 4;                        // number of fault types

  //////////////////////////////////////////////////////////////////////////
  // fault bit positions (status, mask and irq share this layout)
  localparam int F_HIGH = 0;                    // over-voltage
  localparam int F_LOW  = 1;                    // under-voltage
  localparam int F_TMO  = 2;                    // turn-on timeout
  localparam int F_COLD = 3;                    // under-temperature

  //////////////////////////////////////////////////////////////////////////
  // timing: one supervisor tick is one microsecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;    // control
  localparam logic [7:0] OFF_TARGET = 8'h04;    // output target
  localparam logic [7:0] OFF_HIGH   = 8'h08;    // output high limit
  localparam logic [7:0] OFF_LOW    = 8'h0C;    // output low limit
  localparam logic [7:0] OFF_COLD   = 8'h10;    // cold limit
  localparam logic [7:0] OFF_BUDGET = 8'h14;    // turn-on time budget
  localparam logic [7:0] OFF_RAMP   = 8'h18;    // ramp time
  localparam logic [7:0] OFF_ACTION = 8'h1C;    // fault actions
  localparam logic [7:0] OFF_DGLT   = 8'h20;    // deglitch interval
  localparam logic [7:0] OFF_FAULT  = 8'h24;    // latched faults
  localparam logic [7:0] OFF_IRQ    = 8'h28;    // irq status, read clears
  localparam logic [7:0] OFF_MASK   = 8'h2C;    // irq mask
  localparam logic [7:0] OFF_STATE  = 8'h30;    // channel state

  // control fields
  localparam int CTRL_ON    = 0;                // channel on command
  localparam int CTRL_EXT_T = 1;                // 1: external temp sense
  localparam int CTRL_CLR   = 2;                // clear faults, self clears

  //////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [DW-1:0] RST_TARGET = 12'h0_800;
  localparam logic [DW-1:0] RST_HIGH   = 12'hF_FF;
  localparam logic [DW-1:0] RST_LOW    = 12'h0_00;
  localparam logic [DW-1:0] RST_COLD   = 12'h0_00;
  localparam logic [TW-1:0] RST_BUDGET = 16'h2_710;
  localparam logic [TW-1:0] RST_RAMP   = 16'h1_388;
  localparam logic [7:0]    RST_ACTION = 8'h0_0;
  localparam logic [GW-1:0] RST_DGLT   = 8'h0_A;

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ACT_IGNORE = 2'b00,                         // record only
    ACT_DGLT   = 2'b01,                         // deglitched, stay on
    ACT_DG_OFF = 2'b10,                         // deglitched, turn off
    ACT_OFF    = 2'b11                          // immediate, turn off
  } rfs_act_type;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,                            // supply disabled
    ST_RAMP = 2'b01,                            // enabled, servo open
    ST_ON   = 2'b10                             // servo connected
  } rfs_state_type;

endpackage

//--- src/rfs_deglitch.sv
// rail fault supervisor: persistence filter for one fault condition
`timescale 1ns/10ps
module rfs_deglitch
  import rfs_pkg::*;
(
  // clock and reset
  input  wire logic          i_sys_clk,
  input  wire logic          i_srst,
  // condition and settings
  input  wire logic          i_cond,
  input  wire logic          i_bypass,
  input  wire logic          i_tick,
  input  wire logic [GW-1:0] i_interval,
  // filtered result
  output logic               o_hit
);

  logic [GW-1:0] cnt_r;                         // ticks the condition held
  logic [GW-1:0] cnt_nxt;
  logic          hit_nxt;

  // any drop of the condition restarts the wait
  assign cnt_nxt = !i_cond ? '0 :
                   (i_tick && cnt_r < i_interval) ? cnt_r + 1'b1 : cnt_r;
  assign hit_nxt = i_cond && (i_bypass || cnt_r >= i_interval);

  // counter and registered result
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_r <= '0;
      o_hit <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      o_hit <= hit_nxt;
    end
  end

endmodule

//--- src/rfs_servo.sv
// rail fault supervisor: output trim servo toward the target value
`timescale 1ns/10ps
module rfs_servo
  import rfs_pkg::*;
(
  // clock and reset
  input  wire logic          i_sys_clk,
  input  wire logic          i_srst,
  // control
  input  wire logic          i_connect,
  input  wire logic          i_tick,
  input  wire logic [DW-1:0] i_target,
  input  wire logic [DW-1:0] i_sense,
  // trim code, two's complement
  output logic [GW-1:0]      o_trim
);

  localparam logic [GW-1:0] TRIM_MAX = 8'h7_F;
  localparam logic [GW-1:0] TRIM_MIN = 8'h8_0;

  logic up;                                     // output below target
  logic dn;                                     // output above target

  assign up = i_sense < i_target && o_trim != TRIM_MAX;
  assign dn = i_sense > i_target && o_trim != TRIM_MIN;

  // one step per tick; released servo returns to zero trim
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_connect) begin
      o_trim <= '0;
    end else if (i_tick && up) begin
      o_trim <= o_trim + 1'b1;
    end else if (i_tick && dn) begin
      o_trim <= o_trim - 1'b1;
    end
  end

endmodule

//--- dv/rfs_supply_model.sv
// managed supply model: output follows enable with a finite slew
`timescale 1ns/10ps
module rfs_supply_model
  import rfs_pkg::*;
(
  // clock
  input  wire logic          i_sys_clk,
  // enable and settled level
  input  wire logic          i_enable,
  input  wire logic [DW-1:0] i_level,
  // sensed output voltage
  output logic [DW-1:0]      o_sense
);
  //////////////////////////////////////////////////////////////////////////
  // 0x40 per cycle slew, so no limit is jumped
  logic [DW-1:0] goal;                          // level aimed at this cycle
  assign goal = i_enable ? i_level : 12'h000;
  initial o_sense = 12'h000;
  always @(posedge i_sys_clk) begin
    if (o_sense + 12'h040 < goal && o_sense < 12'hFBF) begin
      o_sense <= o_sense + 12'h040;
    end else if (o_sense > goal + 12'h040) begin
      o_sense <= o_sense - 12'h040;
    end else begin
      o_sense <= goal;                          // settle exactly on the goal
    end
  end
endmodule

//--- dv/rfs_top_sva.sv
// rail fault supervisor: port-level checker and its bind
`timescale 1ns/10ps
module rfs_top_sva
  import rfs_pkg::*;
(
  // clock and reset
  input wire logic          i_sys_clk,
  input wire logic          i_srst,
  // apb
  input wire logic          i_psel,
  input wire logic          i_penable,
  input wire logic          i_pwrite,
  input wire logic [7:0]    i_paddr,
  input wire logic [31:0]   i_pwdata,
  input wire logic          o_pready,
  input wire logic          o_pslverr,
  // samples and supply side
  input wire logic [DW-1:0] i_output_sense_input,
  input wire logic [DW-1:0] i_die_temp,
  input wire logic [DW-1:0] i_external_temp_sense,
  input wire logic          o_supply_enable_out,
  input wire logic          o_servo_connected,
  input wire logic [GW-1:0] o_servo_trim,
  // alert
  input wire logic          o_alert_out_n_o,
  input wire logic          o_alert_out_n_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  //////////////////////////////////////////////////////////////////////////
  // shadow limits, updated on the register write edge
  logic          wr;                            // completing write
  logic          clr;                           // clear command this edge
  logic          bad;                           // unmapped address
  logic [DW-1:0] high_r, cold_r;                // shadow limits
  logic [TW-1:0] ramp_r;                        // shadow ramp time
  logic [7:0]    act_r;                         // shadow actions
  logic          ext_r;                         // shadow temp source
  logic [2:0]    clr_h;                         // recent clear commands
  logic [31:0]   en_cnt;                        // cycles since supply enable
  assign wr  = i_psel && i_penable && i_pwrite;
  assign clr = wr && i_paddr == OFF_CTRL && i_pwdata[CTRL_CLR];
  assign bad = i_paddr > OFF_STATE || i_paddr[1:0] != 2'b00;

  // shadows follow the register writes
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      high_r <= RST_HIGH;
      cold_r <= RST_COLD;
      ramp_r <= RST_RAMP;
      act_r  <= RST_ACTION;
      ext_r  <= 1'b0;
    end else if (wr) begin
      if (i_paddr == OFF_HIGH) high_r <= i_pwdata[DW-1:0];
      if (i_paddr == OFF_COLD) cold_r <= i_pwdata[DW-1:0];
      if (i_paddr == OFF_RAMP) ramp_r <= i_pwdata[TW-1:0];
      if (i_paddr == OFF_ACTION) act_r <= i_pwdata[7:0];
      if (i_paddr == OFF_CTRL) ext_r <= i_pwdata[CTRL_EXT_T];
    end
  end

  // clear history; cycles since supply enable
  always_ff @(posedge i_sys_clk) begin
    clr_h  <= i_srst ? 3'b000 : {clr_h[1:0], clr};
    en_cnt <= (i_srst || !o_supply_enable_out) ? '0 : en_cnt + 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  chk_high_alert: assert property (
    i_output_sense_input > high_r && act_r[1:0] != ACT_DGLT && act_r[1:0] != ACT_DG_OFF
    && !clr ##1 !clr |-> ##1 o_alert_out_n_oe) else $error("alert missed over-voltage");
  chk_cold_alert: assert property (
    (ext_r ? i_external_temp_sense : i_die_temp) < cold_r && act_r[7:6] != ACT_DGLT
    && act_r[7:6] != ACT_DG_OFF && !clr ##1 !clr |-> ##1 o_alert_out_n_oe)
    else $error("alert missed cold condition");
  chk_alert_sticky: assert property ($fell(o_alert_out_n_oe) |-> clr_h != 3'b000)
    else $error("alert released without clear");
  chk_alert_data: assert property (o_alert_out_n_oe |-> !o_alert_out_n_o)
    else $error("alert not pulled low");
  chk_servo_ramp: assert property (
    $rose(o_servo_connected) |-> en_cnt + TICK_CYC >= ramp_r * TICK_CYC)
    else $error("servo connected before ramp time");
  chk_servo_gate: assert property (o_servo_connected |-> o_supply_enable_out)
    else $error("servo connected with supply off");
  chk_trim_idle: assert property (
    !o_servo_connected ##1 !o_servo_connected |-> o_servo_trim == 8'h00)
    else $error("trim moves while servo open");
  chk_apb_error: assert property (i_psel && i_penable |-> o_pready && o_pslverr == bad)
    else $error("apb ready or error wrong");
  chk_turn_on: assert property (
    wr && i_paddr == OFF_CTRL && i_pwdata[CTRL_ON] && !o_alert_out_n_oe && !clr_h[0]
    |-> ##[1:2] o_supply_enable_out) else $error("channel did not turn on");
endmodule

bind rfs_top rfs_top_sva chk_u (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_output_sense_input(i_output_sense_input),
  .i_die_temp(i_die_temp), .i_external_temp_sense(i_external_temp_sense),
  .o_supply_enable_out(o_supply_enable_out), .o_servo_connected(o_servo_connected),
  .o_servo_trim(o_servo_trim), .o_alert_out_n_o(o_alert_out_n_o),
  .o_alert_out_n_oe(o_alert_out_n_oe)
);

//--- dv/rfs_top_bench.sv
// rail fault supervisor: self-checking bench over apb
`timescale 1ns/10ps
module rfs_top_bench
  import rfs_pkg::*;
;
  logic          clk, srst, psel, penable, pwrite;          // clock, reset, apb controls
  logic [7:0]    paddr;                                     // apb address
  logic [31:0]   pwdata, prdata;                            // apb data
  logic          pready, pslverr, en, conn, od_o, od_oe, irq; // design outputs
  logic [DW-1:0] sense, level, die_t, ext_t;                // samples
  logic [GW-1:0] trim;                                      // servo trim
  logic [31:0]   q;                                         // last read word
  logic          e;                                         // last read error
  int            fail_count, n_compared, cyc;               // tallies and cycle count
  logic [7:0]    roff [9] = '{OFF_TARGET, OFF_HIGH, OFF_LOW, OFF_BUDGET, OFF_RAMP,
                              OFF_ACTION, OFF_DGLT, OFF_MASK, OFF_CTRL};
  logic [31:0]   rval [9] = '{32'h0000_0800, 32'h0000_0FFF, 32'h0000_0000, 32'h0000_2710,
                              32'h0000_1388, 32'h0000_0000, 32'h0000_000A, 32'h0000_0000,
                              32'h0000_0000};

  //////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  rfs_supply_model sup_u (.i_sys_clk(clk), .i_enable(en), .i_level(level), .o_sense(sense));
  rfs_top dut_u (
    .i_sys_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_output_sense_input(sense), .i_die_temp(die_t),
    .i_external_temp_sense(ext_t), .o_supply_enable_out(en), .o_servo_connected(conn),
    .o_servo_trim(trim), .o_alert_out_n_o(od_o), .o_alert_out_n_oe(od_oe), .o_irq(irq));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, driven just after rising edges
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    level = 12'h800; die_t = 12'h200; ext_t = 12'h050;
    fail_count = 0; n_compared = 0; cyc = 0;
    wt(5);
    srst <= 1'b0;
    // reset values and an unmapped place
    for (int i = 0; i < 9; i++) begin apb(0, roff[i], 0); check(q, rval[i]); end
    apb(0, 8'h40, 0); check(e, 1); check(q, 0);
    // short timers, limits, irqs on, then turn on
    apb(1, OFF_BUDGET, 3); apb(1, OFF_RAMP, 2); apb(1, OFF_DGLT, 3);
    apb(1, OFF_LOW, 32'h0000_0100); apb(1, OFF_HIGH, 32'h0000_0E00); apb(1, OFF_MASK, 15);
    apb(1, OFF_CTRL, 1);
    for (int n = 0; n < 2000 && conn !== 1'b1; n++) @(posedge clk);
    check({conn, en, od_oe}, 3'b110);
    apb(0, OFF_STATE, 0); check(q[1:0], 2'd2);
    // over-voltage, ignore: latched, stays on
    level <= 12'hF00; wt(160);
    check({od_oe, en, irq}, 3'b111);
    apb(0, OFF_FAULT, 0); check(q, 1);
    apb(0, OFF_IRQ, 0); check(q, 1);
    wt(3); check(irq, 0);
    level <= 12'h800; wt(60);
    check(trim[7], 1'b1);
    apb(1, OFF_CTRL, 5); wt(4);
    check(od_oe, 0);
    apb(0, OFF_FAULT, 0); check(q, 0);
    // under-voltage, deglitched-off
    apb(1, OFF_ACTION, 32'h0000_0008); level <= 12'h050; wt(4);
    apb(0, OFF_FAULT, 0); check(q, 0);
    wt(600);
    check({en, od_oe}, 2'b01);
    apb(0, OFF_FAULT, 0); check(q, 2);
    // restart, supply never rises: timeout only
    apb(1, OFF_CTRL, 5); wt(800);
    apb(0, OFF_FAULT, 0); check(q, 4);
    check({en, od_oe}, 2'b11);
    // die temp above cold limit, then cold on external, kept over a clear
    apb(1, OFF_CTRL, 0); level <= 12'h800; wt(20); apb(1, OFF_CTRL, 4);
    apb(1, OFF_COLD, 32'h0000_0100); wt(10);
    apb(0, OFF_FAULT, 0); check(q, 0);
    apb(1, OFF_CTRL, 2); wt(10);
    apb(0, OFF_FAULT, 0); check(q, 8);
    apb(1, OFF_CTRL, 6); wt(10);
    apb(0, OFF_FAULT, 0); check(q, 8);
    check(od_oe, 1);
    report_and_stop();
  end
endmodule
